// >>> tchc_pkg.sv
// Constants shared by the transmit and hardware configuration register bank
package tchc_pkg;

  // Register byte offsets on the host bus
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_TX_CFG     = 8'h70;
  localparam logic [7:0]  OFF_HARDWARE_CONFIG     = 8'h74;
  localparam int          DATA_W         = 32;

  // Transmit configuration fields
  localparam int          TXC_STATUS_FLUSH_BIT  = 15;
  localparam int          TXC_DATA_FLUSH_BIT    = 14;
  localparam int          TXC_OVERRUN_ALLOW_BIT = 2;
  localparam int          TXC_TX_ENABLE_BIT     = 1;
  localparam int          TXC_STOP_BIT          = 0;
  localparam logic [31:0] TXC_RESET             = 32'h0000_0000;

  // Hardware configuration fields
  localparam int          HWC_PORT_ENDIAN_BIT   = 29;
  localparam int          HWC_DIRECT_ENDIAN_BIT = 28;
  localparam int          HWC_STRAP_BIT         = 24;
  localparam int          HWC_MBO_BIT           = 20;
  localparam int          HWC_SIZE_LSB          = 16;
  localparam int          HWC_SIZE_W            = 4;
  localparam int          HWC_TIMEOUT_BIT       = 1;
  localparam int          HWC_SOFT_RESET_REQUEST_BIT          = 0;
  localparam logic [3:0]  HWC_SIZE_RESET        = 4'h5;
  localparam logic [3:0]  HWC_SIZE_MIN          = 4'h2;
  localparam logic [3:0]  HWC_SIZE_MAX          = 4'he;
  localparam logic [1:0]  STRAP_SAMPLE_AGE      = 2'h2;

  // FIFO memory split
  localparam int          BYTES_W          = 15;
  localparam logic [14:0] FIFO_TOTAL_BYTES = 15'h4000;
  localparam int          KB_SHIFT         = 10;
  localparam logic [14:0] TX_STATUS_BYTES  = 15'h0200;
  localparam int          RX_STATUS_SHIFT  = 4;

  // Soft reset wait for the PHY clocks
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          SOFT_RESET_REQUEST_TIMEOUT_NS   = 100000;
  localparam int          SOFT_RESET_REQUEST_TIMEOUT_CYC  = SOFT_RESET_REQUEST_TIMEOUT_NS / CLK_PERIOD_NS;

  // Soft reset sequencer states
  typedef enum logic [0:0] {
    SR_IDLE = 1'b0,
    SR_WAIT = 1'b1
  } tchc_soft_reset_request_state_t;

endpackage

// >>> tchc_soft_reset_request_if.sv
// Handshake between the register bank and the soft reset sequencer
`timescale 1ns/1ps
interface tchc_soft_reset_request_if;
  logic req;      // One-cycle start request
  logic phy_ok;   // PHY clocks running, synchronised
  logic busy;     // Sequence in progress
  logic done;     // One-cycle reset completion
  logic timeout;  // One-cycle timeout event

  modport ctrl (input req, input phy_ok, output busy, output done, output timeout);
  modport regs (output req, output phy_ok, input busy, input done, input timeout);
endinterface

// >>> tchc_soft_reset_request_ctrl.sv
// Soft reset sequencer that waits for the PHY clocks or times out
`timescale 1ns/1ps
module tchc_soft_reset_request_ctrl
  import tchc_pkg::*;
#(
  parameter int TIMEOUT_CYC = SOFT_RESET_REQUEST_TIMEOUT_CYC
) (
  input  wire logic  clk,    // System clock
  input  wire logic  reset,  // Asynchronous reset, active high
  tchc_soft_reset_request_if.ctrl  sr      // Handshake with the register bank
);

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

  tchc_soft_reset_request_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             done_r;
  logic             timeout_r;

  // Sequence: wait for clocks, complete or give up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= SR_IDLE;
    end else begin
      unique case (state_r)
        SR_IDLE: begin
          if (sr.req) begin
            state_r <= SR_WAIT;
          end
        end
        SR_WAIT: begin
          if (sr.phy_ok || cnt_r == CNT_LAST) begin
            state_r <= SR_IDLE;
          end
        end
      endcase
    end
  end

  // Wait counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (state_r == SR_IDLE) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Completion and timeout pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_r    <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      done_r    <= (state_r == SR_WAIT) && sr.phy_ok;
      timeout_r <= (state_r == SR_WAIT) && !sr.phy_ok && cnt_r == CNT_LAST;
    end
  end

  assign sr.busy    = (state_r == SR_WAIT) || done_r || timeout_r;
  assign sr.done    = done_r;
  assign sr.timeout = timeout_r;

endmodule

// >>> tchc_regs.sv
// Transmit and hardware configuration registers behind the SRAM-like host port
`timescale 1ns/1ps
module tchc_regs
  import tchc_pkg::*;
#(
  parameter int SOFT_RESET_REQUEST_TIMEOUT = SOFT_RESET_REQUEST_TIMEOUT_CYC
) (
  input  wire logic               clk,                  // System clock, 50 MHz
  input  wire logic               reset,                // Asynchronous reset, active high
  input  wire logic               bus_cs_n,             // Chip select pin, active low
  input  wire logic               bus_rd_n,             // Read strobe pin, active low
  input  wire logic               bus_wr_n,             // Write strobe pin, active low
  input  wire logic [ADDR_W-1:0]  bus_addr,             // Byte address pins
  input  wire logic [DATA_W-1:0]  bus_data_in,          // Data pins, input side
  output logic      [DATA_W-1:0]  bus_data_out,         // Data pins, output side
  output logic                    bus_data_oe,          // Data pins driven when high
  input  wire logic               crossover_strap,      // Crossover enable strap pin
  input  wire logic               phy_rx_clk_running,   // PHY receive clock alive
  input  wire logic               phy_tx_clk_running,   // PHY transmit clock alive
  input  wire logic               tx_frame_active,      // Transmitter mid-frame
  input  wire logic               tx_status_fifo_full,  // Status FIFO full level
  output logic                    tx_enable,            // Transmitter run
  output logic                    tx_stop_request,      // Finish frame, then halt
  output logic                    tx_suspend,           // Hold off on full status FIFO
  output logic                    tx_status_full_event, // Status FIFO became full
  output logic                    tx_status_ptr_clear,  // Clear status FIFO pointers
  output logic                    tx_data_ptr_clear,    // Clear data FIFO pointers
  output logic                    data_port_endian,     // Port access big endian
  output logic                    direct_access_endian, // Select-pin access big endian
  output logic                    must_be_one,          // Normal operation enable
  output logic      [BYTES_W-1:0] tx_data_fifo_bytes,   // Transmit data FIFO size
  output logic      [BYTES_W-1:0] tx_status_fifo_bytes, // Transmit status FIFO size
  output logic      [BYTES_W-1:0] rx_data_fifo_bytes,   // Receive data FIFO size
  output logic      [BYTES_W-1:0] rx_status_fifo_bytes, // Receive status FIFO size
  output logic                    soft_reset_pulse,     // MAC register reset
  output logic                    error_clear_pulse     // Clear transmit and receive errors
);

  localparam int SYNC_W = 3 + ADDR_W + DATA_W + 3;

  // Total transmit allocation, clamped to the legal range
  function automatic logic [BYTES_W-1:0] tx_total(input logic [HWC_SIZE_W-1:0] sz);
    logic [HWC_SIZE_W-1:0] c;
    c = sz;
    if (c < HWC_SIZE_MIN) begin
      c = HWC_SIZE_MIN;
    end else if (c > HWC_SIZE_MAX) begin
      c = HWC_SIZE_MAX;
    end
    return BYTES_W'({11'h000, c} << KB_SHIFT);
  endfunction

  tchc_soft_reset_request_if sr ();

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              cs_n_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic              strap_s;
  logic              phy_rx_s;
  logic              phy_tx_s;
  logic              wr_n_d_r;
  logic              wr_take;
  logic              wr_tx_cfg;
  logic              wr_hardware_config;
  logic              halted;
  logic              tx_on_r;
  logic              stop_r;
  logic              allow_r;
  logic              full_d_r;
  logic              port_endian_r;
  logic              direct_endian_r;
  logic              mbo_r;
  logic [3:0]        size_r;
  logic              timeout_flag_r;
  logic              strap_r;
  logic [1:0]        strap_age_r;
  logic [DATA_W-1:0] tx_cfg_rd;
  logic [DATA_W-1:0] hardware_config_rd;
  logic [BYTES_W-1:0] tx_total_b;
  logic [BYTES_W-1:0] rx_total_b;

  // Two-flop synchronisers for every pin input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= {3'b111, {(ADDR_W + DATA_W + 3){1'b0}}};
      sync2_r <= {3'b111, {(ADDR_W + DATA_W + 3){1'b0}}};
    end else begin
      sync1_r <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in,
                  crossover_strap, phy_rx_clk_running, phy_tx_clk_running};
      sync2_r <= sync1_r;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, addr_s, wdata_s, strap_s, phy_rx_s, phy_tx_s} = sync2_r;

  // Write taken on the trailing edge of the write strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_n_d_r <= 1'b1;
    end else begin
      wr_n_d_r <= wr_n_s;
    end
  end

  assign wr_take   = wr_n_s && !wr_n_d_r && !cs_n_s;
  assign wr_tx_cfg = wr_take && addr_s == OFF_TX_CFG;
  assign wr_hardware_config = wr_take && addr_s == OFF_HARDWARE_CONFIG && !sr.busy;
  assign halted    = stop_r && !tx_frame_active;

  // Soft reset sequencer hookup
  assign sr.req    = wr_hardware_config && wdata_s[HWC_SOFT_RESET_REQUEST_BIT];
  assign sr.phy_ok = phy_rx_s && phy_tx_s;

  tchc_soft_reset_request_ctrl #(
    .TIMEOUT_CYC (SOFT_RESET_REQUEST_TIMEOUT)
  ) u_soft_reset_request (
    .clk   (clk),
    .reset (reset),
    .sr    (sr)
  );

  // Transmitter enable and stop request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_on_r <= 1'b0;
      stop_r  <= 1'b0;
    end else if (sr.done) begin
      tx_on_r <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      if (wr_tx_cfg) begin
        tx_on_r <= wdata_s[TXC_TX_ENABLE_BIT];
      end else if (halted) begin
        tx_on_r <= 1'b0;
      end
      if (halted) begin
        stop_r <= 1'b0;
      end else if (wr_tx_cfg && !stop_r) begin
        stop_r <= wdata_s[TXC_STOP_BIT];
      end
    end
  end

  // Overrun allow control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      allow_r <= 1'b0;
    end else if (sr.done) begin
      allow_r <= 1'b0;
    end else if (wr_tx_cfg) begin
      allow_r <= wdata_s[TXC_OVERRUN_ALLOW_BIT];
    end
  end

  // Transmit side outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_enable            <= 1'b0;
      tx_stop_request      <= 1'b0;
      tx_suspend           <= 1'b0;
      full_d_r             <= 1'b0;
      tx_status_full_event <= 1'b0;
    end else begin
      tx_enable            <= tx_on_r;
      tx_stop_request      <= stop_r;
      tx_suspend           <= tx_status_fifo_full && !allow_r;
      full_d_r             <= tx_status_fifo_full;
      tx_status_full_event <= tx_status_fifo_full && !full_d_r;
    end
  end

  // Self-clearing flush strobes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_status_ptr_clear <= 1'b0;
      tx_data_ptr_clear   <= 1'b0;
    end else begin
      tx_status_ptr_clear <= wr_tx_cfg && wdata_s[TXC_STATUS_FLUSH_BIT];
      tx_data_ptr_clear   <= wr_tx_cfg && wdata_s[TXC_DATA_FLUSH_BIT];
    end
  end

  // Endian bits, untouched by soft reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_endian_r   <= 1'b0;
      direct_endian_r <= 1'b0;
    end else if (wr_hardware_config) begin
      port_endian_r   <= wdata_s[HWC_PORT_ENDIAN_BIT];
      direct_endian_r <= wdata_s[HWC_DIRECT_ENDIAN_BIT];
    end
  end

  // Must-be-one bit and transmit size, reinitialised by soft reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mbo_r  <= 1'b0;
      size_r <= HWC_SIZE_RESET;
    end else if (sr.done) begin
      mbo_r  <= 1'b0;
      size_r <= HWC_SIZE_RESET;
    end else if (wr_hardware_config) begin
      mbo_r  <= wdata_s[HWC_MBO_BIT];
      size_r <= wdata_s[HWC_SIZE_LSB +: HWC_SIZE_W];
    end
  end

  // Timeout flag: set by a failed attempt, cleared by a new request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timeout_flag_r <= 1'b0;
    end else if (sr.timeout) begin
      timeout_flag_r <= 1'b1;
    end else if (sr.req) begin
      timeout_flag_r <= 1'b0;
    end
  end

  // Strap caught once the synchroniser holds a post-reset pin value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_r     <= 1'b0;
      strap_age_r <= 2'h0;
    end else if (strap_age_r != STRAP_SAMPLE_AGE + 2'h1) begin
      strap_age_r <= strap_age_r + 2'h1;
      if (strap_age_r == STRAP_SAMPLE_AGE) begin
        strap_r <= strap_s;
      end
    end
  end

  // Soft reset and error clear pulses to the MAC
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_reset_pulse  <= 1'b0;
      error_clear_pulse <= 1'b0;
    end else begin
      soft_reset_pulse  <= sr.done;
      error_clear_pulse <= sr.done;
    end
  end

  // Configuration level outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_port_endian     <= 1'b0;
      direct_access_endian <= 1'b0;
      must_be_one          <= 1'b0;
    end else begin
      data_port_endian     <= port_endian_r;
      direct_access_endian <= direct_endian_r;
      must_be_one          <= mbo_r;
    end
  end

  // FIFO memory split
  assign tx_total_b = tx_total(size_r);
  assign rx_total_b = FIFO_TOTAL_BYTES - tx_total_b;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_data_fifo_bytes   <= '0;
      tx_status_fifo_bytes <= '0;
      rx_data_fifo_bytes   <= '0;
      rx_status_fifo_bytes <= '0;
    end else begin
      tx_status_fifo_bytes <= TX_STATUS_BYTES;
      tx_data_fifo_bytes   <= tx_total_b - TX_STATUS_BYTES;
      rx_status_fifo_bytes <= rx_total_b >> RX_STATUS_SHIFT;
      rx_data_fifo_bytes   <= rx_total_b - (rx_total_b >> RX_STATUS_SHIFT);
    end
  end

  // Read images; reserved bits stay zero
  always_comb begin
    tx_cfg_rd = '0;
    tx_cfg_rd[TXC_OVERRUN_ALLOW_BIT] = allow_r;
    tx_cfg_rd[TXC_TX_ENABLE_BIT]     = tx_on_r;
    tx_cfg_rd[TXC_STOP_BIT]          = stop_r;
  end

  always_comb begin
    hardware_config_rd = '0;
    hardware_config_rd[HWC_PORT_ENDIAN_BIT]   = port_endian_r;
    hardware_config_rd[HWC_DIRECT_ENDIAN_BIT] = direct_endian_r;
    hardware_config_rd[HWC_STRAP_BIT]         = strap_r;
    hardware_config_rd[HWC_MBO_BIT]           = mbo_r;
    hardware_config_rd[HWC_SIZE_LSB +: HWC_SIZE_W] = size_r;
    hardware_config_rd[HWC_TIMEOUT_BIT]       = timeout_flag_r;
    hardware_config_rd[HWC_SOFT_RESET_REQUEST_BIT]          = sr.busy;
  end

  // Read data and pin drive while chip select and read strobe are low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
    end else begin
      bus_data_oe <= !cs_n_s && !rd_n_s;
      if (addr_s == OFF_TX_CFG) begin
        bus_data_out <= tx_cfg_rd;
      end else if (addr_s == OFF_HARDWARE_CONFIG) begin
        bus_data_out <= hardware_config_rd;
      end else begin
        bus_data_out <= '0;
      end
    end
  end

endmodule

// >>> tchc_regs_sva.sv
// Port assertions for the transmit and hardware configuration registers
`timescale 1ns/1ps
module tchc_regs_sva
  import tchc_pkg::*;
(
  input wire logic               clk,                  // System clock
  input wire logic               reset,                // Async reset
  input wire logic               tx_frame_active,      // Mid-frame
  input wire logic               tx_status_fifo_full,  // Status FIFO full
  input wire logic               tx_enable,            // Transmitter run
  input wire logic               tx_stop_request,      // Stop pending
  input wire logic               tx_suspend,           // Hold off
  input wire logic               tx_status_full_event, // Full event
  input wire logic               tx_status_ptr_clear,  // Status flush
  input wire logic               tx_data_ptr_clear,    // Data flush
  input wire logic               data_port_endian,     // Port order
  input wire logic               direct_access_endian, // Direct order
  input wire logic               must_be_one,          // Must-be-one copy
  input wire logic [BYTES_W-1:0] tx_data_fifo_bytes,   // Tx data size
  input wire logic [BYTES_W-1:0] tx_status_fifo_bytes, // Tx status size
  input wire logic [BYTES_W-1:0] rx_data_fifo_bytes,   // Rx data size
  input wire logic [BYTES_W-1:0] rx_status_fifo_bytes, // Rx status size
  input wire logic               soft_reset_pulse,     // Soft reset done
  input wire logic               error_clear_pulse     // Error clear
);
  logic [16:0] rx_sum;
  logic [16:0] all_sum;

  // Sums of the memory split
  assign rx_sum = {2'h0, rx_data_fifo_bytes} + {2'h0, rx_status_fifo_bytes};
  assign all_sum = rx_sum + {2'h0, tx_data_fifo_bytes} + {2'h0, tx_status_fifo_bytes};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Stop pending with the line idle
  sequence s_halt;
    tx_stop_request && !tx_frame_active;
  endsequence
  // Soft reset completion
  sequence s_soft_reset_request_done;
    soft_reset_pulse && error_clear_pulse;
  endsequence

  property p_suspend;
    !$past(tx_status_fifo_full) |-> !tx_suspend;
  endproperty
  property p_event;
    $rose(tx_status_fifo_full) |-> ##[1:2] tx_status_full_event;
  endproperty
  property p_event_pulse;
    tx_status_full_event |=> !tx_status_full_event;
  endproperty
  property p_sflush;
    tx_status_ptr_clear |=> !tx_status_ptr_clear;
  endproperty
  property p_dflush;
    tx_data_ptr_clear |=> !tx_data_ptr_clear;
  endproperty
  property p_halt;
    s_halt |-> ##[1:2] !tx_stop_request;
  endproperty
  property p_en_halt;
    $fell(tx_stop_request) |-> !tx_enable;
  endproperty
  property p_soft_reset_request_pair;
    soft_reset_pulse |-> error_clear_pulse ##1 !soft_reset_pulse;
  endproperty
  property p_soft_reset_request_regs;
    s_soft_reset_request_done |-> ##[1:2] (!tx_enable && !must_be_one && tx_data_fifo_bytes == 15'h1200);
  endproperty
  property p_endian;
    s_soft_reset_request_done |=> ($stable(data_port_endian) && $stable(direct_access_endian)) [*3];
  endproperty
  property p_split;
    rx_status_fifo_bytes != 15'h0 |-> all_sum == 17'h4000 &&
      tx_status_fifo_bytes == 15'h0200 && {rx_status_fifo_bytes, 4'h0} == rx_sum;
  endproperty

  a_suspend: assert property (p_suspend)
    else $error("suspend without full status FIFO");
  a_event: assert property (p_event)
    else $error("no full event after status FIFO filled");
  a_event_pulse: assert property (p_event_pulse)
    else $error("full event longer than one cycle");
  a_sflush: assert property (p_sflush)
    else $error("status flush did not self clear");
  a_dflush: assert property (p_dflush)
    else $error("data flush did not self clear");
  a_halt: assert property (p_halt)
    else $error("stop request stayed after halt");
  a_en_halt: assert property (p_en_halt)
    else $error("enable still set after halt");
  a_soft_reset_request_pair: assert property (p_soft_reset_request_pair)
    else $error("soft reset pulse without error clear");
  a_soft_reset_request_regs: assert property (p_soft_reset_request_regs)
    else $error("registers not reinitialised by soft reset");
  a_endian: assert property (p_endian)
    else $error("endian bits changed by soft reset");
  a_split: assert property (p_split)
    else $error("FIFO split inconsistent");
endmodule

bind tchc_regs tchc_regs_sva u_sva (
  .clk, .reset, .tx_frame_active, .tx_status_fifo_full, .tx_enable, .tx_stop_request,
  .tx_suspend, .tx_status_full_event, .tx_status_ptr_clear, .tx_data_ptr_clear,
  .data_port_endian, .direct_access_endian, .must_be_one, .tx_data_fifo_bytes,
  .tx_status_fifo_bytes, .rx_data_fifo_bytes, .rx_status_fifo_bytes, .soft_reset_pulse,
  .error_clear_pulse
);

// >>> tchc_host_model.sv
// Host processor model on the SRAM-like register port
`timescale 1ns/1ps
module tchc_host_model
  import tchc_pkg::*;
(
  input  wire logic              clk,          // System clock
  output logic                   bus_cs_n,     // Chip select
  output logic                   bus_rd_n,     // Read strobe
  output logic                   bus_wr_n,     // Write strobe
  output logic      [ADDR_W-1:0] bus_addr,     // Byte address
  output logic      [DATA_W-1:0] bus_data_in,  // Pins as the device sees them
  input  wire logic [DATA_W-1:0] bus_data_out, // Device read data
  input  wire logic              bus_data_oe   // Device drives pins
);
  localparam int HOLD = 4;
  logic [DATA_W-1:0] wdat;
  logic              drv;

  // Released pins show the device read data while the device drives, else the inverse of the last host value
  assign bus_data_in = drv ? wdat : (bus_data_oe ? bus_data_out : ~wdat);

  // Bus idle at time zero
  initial begin
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = '0;
    wdat = '0;
    drv = 1'b0;
  end

  // Write: strobe and hold long enough for the pin synchronisers
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_cs_n <= 1'b0;
    bus_addr <= a;
    wdat <= d;
    drv <= 1'b1;
    bus_wr_n <= 1'b0;
    repeat (HOLD) @(posedge clk);
    bus_wr_n <= 1'b1;
    repeat (HOLD) @(posedge clk);
    bus_cs_n <= 1'b1;
    drv <= 1'b0;
    bus_addr <= ~a;
    repeat (HOLD) @(posedge clk);
  endtask

  // Read: hold strobes until the device drives, then release
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    bus_cs_n <= 1'b0;
    bus_rd_n <= 1'b0;
    bus_addr <= a;
    @(posedge clk);
    while (bus_data_oe !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    d = (bus_data_oe === 1'b1) ? bus_data_out : 'x;
    bus_cs_n <= 1'b1;
    bus_rd_n <= 1'b1;
    bus_addr <= ~a;
    repeat (HOLD) @(posedge clk);
  endtask
endmodule

// >>> testbench.sv
// Self-checking testbench for the transmit and hardware configuration registers
`timescale 1ns/1ps
module testbench
  import tchc_pkg::*;
;
  localparam int TO_CYC = 20;
  logic               clk, reset, crossover_strap, phy_rx_clk_running, phy_tx_clk_running;
  logic               tx_frame_active, tx_status_fifo_full, bus_cs_n, bus_rd_n, bus_wr_n;
  logic [ADDR_W-1:0]  bus_addr;
  logic [DATA_W-1:0]  bus_data_in, bus_data_out, rv;
  logic               bus_data_oe, tx_enable, tx_stop_request, tx_suspend, tx_status_full_event;
  logic               tx_status_ptr_clear, tx_data_ptr_clear, data_port_endian;
  logic               direct_access_endian, must_be_one, soft_reset_pulse, error_clear_pulse;
  logic [BYTES_W-1:0] tx_data_fifo_bytes, tx_status_fifo_bytes, rx_data_fifo_bytes;
  logic [BYTES_W-1:0] rx_status_fifo_bytes;
  int                 failures, num_checks, cycles, n_soft_reset_request, n_evt, n_sfl, n_dfl;

  tchc_regs #(.SOFT_RESET_REQUEST_TIMEOUT(TO_CYC)) dut (
    .clk, .reset, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr, .bus_data_in, .bus_data_out,
    .bus_data_oe, .crossover_strap, .phy_rx_clk_running, .phy_tx_clk_running, .tx_frame_active,
    .tx_status_fifo_full, .tx_enable, .tx_stop_request, .tx_suspend, .tx_status_full_event,
    .tx_status_ptr_clear, .tx_data_ptr_clear, .data_port_endian, .direct_access_endian,
    .must_be_one, .tx_data_fifo_bytes, .tx_status_fifo_bytes, .rx_data_fifo_bytes,
    .rx_status_fifo_bytes, .soft_reset_pulse, .error_clear_pulse
  );
  tchc_host_model u_host (
    .clk, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe
  );

  always #10 clk = ~clk;

  // Count pulses and cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_soft_reset_request <= n_soft_reset_request + int'(soft_reset_pulse === 1'b1 && error_clear_pulse === 1'b1);
    n_evt <= n_evt + int'(tx_status_full_event === 1'b1);
    n_sfl <= n_sfl + int'(tx_status_ptr_clear === 1'b1);
    n_dfl <= n_dfl + int'(tx_data_ptr_clear === 1'b1);
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, rv);
    check(name, rv, exp);
  endtask

  task automatic check_split(input int s);
    check("tx_status_bytes", tx_status_fifo_bytes, 512);
    check("tx_data_bytes", tx_data_fifo_bytes, s * 1024 - 512);
    check("rx_status_bytes", rx_status_fifo_bytes, (16384 - s * 1024) / 16);
    check("rx_data_bytes", rx_data_fifo_bytes, (16384 - s * 1024) * 15 / 16);
  endtask

  task automatic t_reset_values();
    rchk("tx_cfg_reset", OFF_TX_CFG, 32'h0);
    rchk("hardware_config_reset", OFF_HARDWARE_CONFIG, 32'h0105_0000);
    rchk("unmapped_read", 8'h60, 32'h0);
    check_split(5);
  endtask

  task automatic t_sizes();
    logic [3:0] sz[3] = '{4'h2, 4'h8, 4'he};
    foreach (sz[i]) begin
      u_host.wr(OFF_HARDWARE_CONFIG, {12'hfff, sz[i], 16'hfffe});
      rchk("hardware_config_rw", OFF_HARDWARE_CONFIG, {12'h311, sz[i], 16'h0});
      check_split(int'(sz[i]));
      check("port_endian", data_port_endian, 1'b1);
      check("direct_endian", direct_access_endian, 1'b1);
      check("must_be_one", must_be_one, 1'b1);
    end
  endtask

  task automatic t_soft_reset();
    u_host.wr(OFF_HARDWARE_CONFIG, 32'h3010_0001);
    check("soft_reset_request_count", n_soft_reset_request, 1);
    check("port_endian_kept", data_port_endian, 1'b1);
    check("mbo_cleared", must_be_one, 1'b0);
    rchk("hardware_config_after_soft_reset_request", OFF_HARDWARE_CONFIG, 32'h3105_0000);
    check_split(5);
  endtask

  task automatic t_timeout();
    phy_rx_clk_running <= 1'b0;
    u_host.wr(OFF_HARDWARE_CONFIG, 32'h3005_0001);
    repeat (TO_CYC + 10) @(posedge clk);
    rchk("hardware_config_timeout", OFF_HARDWARE_CONFIG, 32'h3105_0002);
    check("soft_reset_request_count_to", n_soft_reset_request, 1);
    phy_rx_clk_running <= 1'b1;
    u_host.wr(OFF_HARDWARE_CONFIG, 32'h3005_0001);
    rchk("hardware_config_retry", OFF_HARDWARE_CONFIG, 32'h3105_0000);
    check("soft_reset_request_count_retry", n_soft_reset_request, 2);
  endtask

  task automatic t_transmit();
    u_host.wr(OFF_TX_CFG, 32'h0000_0002);
    check("tx_enable_on", tx_enable, 1'b1);
    tx_status_fifo_full <= 1'b1;
    repeat (5) @(posedge clk);
    check("suspend_on", tx_suspend, 1'b1);
    check("full_event_a", n_evt, 1);
    tx_status_fifo_full <= 1'b0;
    u_host.wr(OFF_TX_CFG, 32'h0000_0006);
    tx_status_fifo_full <= 1'b1;
    repeat (5) @(posedge clk);
    check("suspend_off", tx_suspend, 1'b0);
    check("full_event_b", n_evt, 2);
    tx_status_fifo_full <= 1'b0;
  endtask

  task automatic t_stop();
    tx_frame_active <= 1'b1;
    u_host.wr(OFF_TX_CFG, 32'h0000_0007);
    check("stop_set", tx_stop_request, 1'b1);
    u_host.wr(OFF_TX_CFG, 32'h0000_0006);
    rchk("stop_held", OFF_TX_CFG, 32'h0000_0007);
    tx_frame_active <= 1'b0;
    repeat (5) @(posedge clk);
    check("stop_clear", tx_stop_request, 1'b0);
    check("enable_clear", tx_enable, 1'b0);
    rchk("tx_cfg_halted", OFF_TX_CFG, 32'h0000_0004);
  endtask

  task automatic t_flush();
    u_host.wr(OFF_TX_CFG, 32'hffff_c004);
    rchk("tx_cfg_flush", OFF_TX_CFG, 32'h0000_0004);
    check("status_flush", n_sfl, 1);
    check("data_flush", n_dfl, 1);
    u_host.wr(8'h60, 32'hffff_ffff);
    rchk("unmapped_write", OFF_TX_CFG, 32'h0000_0004);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset, then run every scenario
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    crossover_strap = 1'b1;
    phy_rx_clk_running = 1'b1;
    phy_tx_clk_running = 1'b1;
    tx_frame_active = 1'b0;
    tx_status_fifo_full = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_sizes();
    t_soft_reset();
    t_timeout();
    t_transmit();
    t_stop();
    t_flush();
    tally_and_finish();
  end
endmodule
